// ==== core/lct_top.sv ====
// Purpose: Trigger and capture control of a multi-channel logic sampler
// Assumes: Settings on CFG are stable before START; records go to a ring memory outside
// Notes:   Sample rate tops out at the 40 MHz system clock
`default_nettype none
`include "lct_defs.svh"

module lct_top (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST,
  // Host command and settings
  input  wire lct_pkg::lct_cfg_t      CFG,
  input  wire logic                   START,
  input  wire logic                   CANCEL,
  // Probe pins
  input  wire logic [`LCT_CHANS-1:0]  PROBE,
  input  wire logic                   OUTSIDE_SAMPLE_CLOCK_PIN,
  // Sample memory write port
  output logic                        WR_EN,
  output logic [`LCT_CNT_W-1:0]       WR_ADDR,
  output lct_pkg::lct_rec_t           WR_DATA,
  // Status
  output logic                        BUSY,
  output logic                        TRIGGERED,
  output logic                        DONE,
  output logic                        ABORTED,
  output logic [`LCT_CNT_W-1:0]       FIRST_ADDR,
  output logic [`LCT_CNT_W-1:0]       REC_COUNT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lct_pkg::lct_state_t     state_reg;
  lct_pkg::lct_cfg_t       cfg_reg;
  logic [`LCT_CHANS-1:0]   probe_s1_reg, probe_s2_reg;
  logic                    eclk_s1_reg, eclk_s2_reg, eclk_s3_reg;
  logic [`LCT_DIV_W-1:0]   div_reg;
  logic                    prev_reg, prev_ok_reg;
  logic [`LCT_CNT_W-1:0]   need_reg, started_reg, wptr_reg, filled_reg;
  logic [1:0]              drain_reg;
  logic                    tick, strobe, sel, hit, new_run, take;
  logic                    feed, cut, flush, tag, rec_valid;
  logic [3:0]              hit_vec;
  logic [`LCT_CNT_W-1:0]   cnt_eff;
  lct_pkg::lct_rec_t       rec;

  function automatic logic [`LCT_CNT_W-1:0] post_need(input logic [`LCT_CNT_W-1:0] cnt,
                                                       input lct_pkg::lct_pos_t pos);
    logic [`LCT_CNT_W+2:0] prod;
    prod = {3'h0, cnt} * {{`LCT_CNT_W{1'b0}}, pos};
    return cnt - prod[`LCT_CNT_W+1:`LCT_QTR_SH];
  endfunction : post_need

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      probe_s1_reg <= '0;
      probe_s2_reg <= '0;
      eclk_s1_reg  <= 1'b0;
      eclk_s2_reg  <= 1'b0;
      eclk_s3_reg  <= 1'b0;
    end else begin
      probe_s1_reg <= PROBE;
      probe_s2_reg <= probe_s1_reg;
      eclk_s1_reg  <= OUTSIDE_SAMPLE_CLOCK_PIN;
      eclk_s2_reg  <= eclk_s1_reg;
      eclk_s3_reg  <= eclk_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sample strobe
  // ----------------------------------------------------------------
  // Internal divider or pin
  always_ff @(posedge CLK) begin
    if (RST || state_reg == lct_pkg::LCT_IDLE) begin
      div_reg <= '0;
    end else begin
      div_reg <= tick ? cfg_reg.rate_div : div_reg - 1'b1;
    end
  end

  always_comb begin
    tick   = (div_reg == '0);
    strobe = (state_reg == lct_pkg::LCT_ARMED || state_reg == lct_pkg::LCT_POST) && !CANCEL &&
             (cfg_reg.use_pin_clock ? (eclk_s2_reg && !eclk_s3_reg) : tick);
  end

  // ----------------------------------------------------------------
  // Trigger match
  // ----------------------------------------------------------------
  // Four conditions, one hit
  always_comb begin
    sel     = probe_s2_reg[cfg_reg.chan];
    hit_vec = '0;
    unique case (cfg_reg.cond)
      lct_pkg::LCT_TRIG_NONE: hit_vec = '0;
      lct_pkg::LCT_TRIG_HIGH: hit_vec[0] = sel;
      lct_pkg::LCT_TRIG_LOW:  hit_vec[1] = !sel;
      lct_pkg::LCT_TRIG_RISE: hit_vec[2] = prev_ok_reg && sel && !prev_reg;
      lct_pkg::LCT_TRIG_FALL: hit_vec[3] = prev_ok_reg && !sel && prev_reg;
      default:                hit_vec = '0;
    endcase
    hit = |hit_vec;
  end

  always_ff @(posedge CLK) begin
    if (RST || state_reg == lct_pkg::LCT_IDLE) begin
      prev_reg    <= 1'b0;
      prev_ok_reg <= 1'b0;
    end else if (strobe) begin
      prev_reg    <= sel;
      prev_ok_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Feed decision
  // ----------------------------------------------------------------
  always_comb begin
    feed  = 1'b0;
    cut   = 1'b0;
    flush = 1'b0;
    tag   = (state_reg == lct_pkg::LCT_POST);
    take  = 1'b0;
    if (strobe && state_reg == lct_pkg::LCT_ARMED) begin
      // Stop on trigger when nothing follows
      if (hit && need_reg == '0) begin
        flush = 1'b1;
      end else begin
        feed = 1'b1;
        cut  = hit;
        tag  = hit;
        take = hit;
      end
    end else if (strobe) begin
      // Close once the post share is full
      if (started_reg == need_reg && new_run) begin
        flush = 1'b1;
      end else begin
        feed = 1'b1;
        take = new_run;
      end
    end
  end

  lct_runlen u_runlen (
    .clk       (CLK),
    .rst       (RST),
    .en        (feed),
    .data      (probe_s2_reg),
    .tag       (tag),
    .cut       (cut),
    .flush     (flush),
    .clr       (START && state_reg == lct_pkg::LCT_IDLE),
    .raw       (!cfg_reg.run_length_capture_mode),
    .new_run   (new_run),
    .rec_valid (rec_valid),
    .rec       (rec)
  );

  // ----------------------------------------------------------------
  // Capture sequence
  // ----------------------------------------------------------------
  // Count clamped to one and the maximum
  always_comb begin
    cnt_eff = (CFG.count == '0) ? `LCT_CNT_W'(1) :
              (CFG.count > `LCT_MAX_COUNT) ? `LCT_MAX_COUNT : CFG.count;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg   <= lct_pkg::LCT_IDLE;
      cfg_reg     <= '0;
      need_reg    <= '0;
      started_reg <= '0;
      drain_reg   <= '0;
      BUSY        <= 1'b0;
      TRIGGERED   <= 1'b0;
      DONE        <= 1'b0;
      ABORTED     <= 1'b0;
    end else begin
      DONE    <= 1'b0;
      ABORTED <= 1'b0;
      unique case (state_reg)
        lct_pkg::LCT_IDLE: begin
          if (START) begin
            cfg_reg       <= CFG;
            cfg_reg.count <= cnt_eff;
            started_reg   <= '0;
            BUSY          <= 1'b1;
            TRIGGERED     <= (CFG.cond == lct_pkg::LCT_TRIG_NONE);
            if (CFG.cond == lct_pkg::LCT_TRIG_NONE) begin
              need_reg  <= cnt_eff;
              state_reg <= lct_pkg::LCT_POST;
            end else begin
              need_reg  <= post_need(cnt_eff, CFG.pos);
              state_reg <= lct_pkg::LCT_ARMED;
            end
          end
        end
        lct_pkg::LCT_ARMED, lct_pkg::LCT_POST: begin
          if (take) begin
            started_reg <= started_reg + 1'b1;
          end
          if (strobe && hit && state_reg == lct_pkg::LCT_ARMED) begin
            TRIGGERED <= 1'b1;
            state_reg <= flush ? lct_pkg::LCT_DRAIN : lct_pkg::LCT_POST;
          end else if (flush) begin
            state_reg <= lct_pkg::LCT_DRAIN;
          end
          drain_reg <= `LCT_DRAIN_CYC;
        end
        lct_pkg::LCT_DRAIN: begin
          // Lets the last record reach the memory port
          drain_reg <= drain_reg - 1'b1;
          if (drain_reg == '0) begin
            state_reg <= lct_pkg::LCT_IDLE;
            BUSY      <= 1'b0;
            DONE      <= 1'b1;
          end
        end
      endcase
      if (CANCEL && state_reg != lct_pkg::LCT_IDLE) begin
        state_reg <= lct_pkg::LCT_IDLE;
        BUSY      <= 1'b0;
        ABORTED   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ring write port
  // ----------------------------------------------------------------
  // Ring of count entries keeps the newest pre records
  always_ff @(posedge CLK) begin
    if (RST || (START && state_reg == lct_pkg::LCT_IDLE)) begin
      WR_EN      <= 1'b0;
      WR_ADDR    <= '0;
      WR_DATA    <= '0;
      wptr_reg   <= '0;
      filled_reg <= '0;
    end else begin
      WR_EN <= rec_valid && state_reg != lct_pkg::LCT_IDLE && !CANCEL;
      if (rec_valid && state_reg != lct_pkg::LCT_IDLE && !CANCEL) begin
        WR_ADDR  <= wptr_reg;
        WR_DATA  <= rec;
        wptr_reg <= (wptr_reg == cfg_reg.count - 1'b1) ? '0 : wptr_reg + 1'b1;
        if (filled_reg != cfg_reg.count) begin
          filled_reg <= filled_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      FIRST_ADDR <= '0;
      REC_COUNT  <= '0;
    end else if (state_reg == lct_pkg::LCT_DRAIN && drain_reg == '0) begin
      FIRST_ADDR <= (filled_reg == cfg_reg.count) ? wptr_reg : '0;
      REC_COUNT  <= filled_reg;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  one_condition_a: assert property (@(posedge CLK) disable iff (RST) $onehot0(hit_vec))
    else $error("More than one trigger condition active");
  edge_history_a: assert property (@(posedge CLK) disable iff (RST)
    (|hit_vec[3:2]) |-> prev_ok_reg && (prev_reg != sel))
    else $error("Edge seen without a previous sample");
  position_share_a: assert property (@(posedge CLK) disable iff (RST)
    (START && !BUSY && CFG.cond != lct_pkg::LCT_TRIG_NONE) |=>
    ((cfg_reg.pos == lct_pkg::LCT_POS_100) == (need_reg == '0)) && need_reg <= cfg_reg.count)
    else $error("Post share wrong for trigger position");
  full_pre_a: assert property (@(posedge CLK) disable iff (RST)
    (strobe && hit && state_reg == lct_pkg::LCT_ARMED && need_reg == '0) |-> !feed ##1
    state_reg == lct_pkg::LCT_DRAIN ##1 !$rose(WR_DATA.post))
    else $error("All-before capture did not stop on trigger");
  post_exact_a: assert property (@(posedge CLK) disable iff (RST)
    DONE |-> started_reg == need_reg)
    else $error("Post record count differs from share");
  self_end_a: assert property (@(posedge CLK) disable iff (RST || ABORTED)
    $rose(state_reg == lct_pkg::LCT_DRAIN) |-> ##[4:5] DONE)
    else $error("Capture did not end after drain");
  count_limit_a: assert property (@(posedge CLK) disable iff (RST)
    BUSY |-> cfg_reg.count != '0 && cfg_reg.count <= `LCT_MAX_COUNT && WR_ADDR < cfg_reg.count)
    else $error("Count or address out of range");
  untrig_start_a: assert property (@(posedge CLK) disable iff (RST)
    (START && !BUSY && CFG.cond == lct_pkg::LCT_TRIG_NONE) |=> state_reg == lct_pkg::LCT_POST && TRIGGERED)
    else $error("Untriggered capture not storing at once");
  cancel_stop_a: assert property (@(posedge CLK) disable iff (RST)
    (CANCEL && BUSY) |=> !BUSY && !WR_EN && !strobe ##1 !WR_EN)
    else $error("Cancel did not stop sampling");
  start_arms_a: assert property (@(posedge CLK) disable iff (RST)
    (START && !BUSY) |=> BUSY && cfg_reg.chan == $past(CFG.chan))
    else $error("Start did not arm with settings");
  rate_source_a: assert property (@(posedge CLK) disable iff (RST)
    strobe |-> (cfg_reg.use_pin_clock ? $rose(eclk_s2_reg) : div_reg == '0))
    else $error("Strobe from wrong sample clock");
  raw_words_a: assert property (@(posedge CLK) disable iff (RST)
    (WR_EN && !cfg_reg.run_length_capture_mode) |-> WR_DATA.run == `LCT_RUN_RAW)
    else $error("Raw mode wrote a run record");
  done_report_a: assert property (@(posedge CLK) disable iff (RST)
    DONE |-> !BUSY && REC_COUNT <= cfg_reg.count ##1 !DONE)
    else $error("Completion report malformed");

  trig_hit_c:   cover property (@(posedge CLK) disable iff (RST) strobe && hit && state_reg == lct_pkg::LCT_ARMED);
  done_c:       cover property (@(posedge CLK) disable iff (RST) DONE && TRIGGERED);
  cancel_c:     cover property (@(posedge CLK) disable iff (RST) ABORTED);
  rle_record_c: cover property (@(posedge CLK) disable iff (RST) WR_EN && WR_DATA.run > `LCT_RUN_ONE);

endmodule : lct_top

`default_nettype wire

// ==== core/lct_defs.svh ====
// Purpose: Named constants of the logic capture trigger block
// Assumes: Included by the package and by the design modules
// Notes:   Definitions only
`ifndef LCT_DEFS_SVH
`define LCT_DEFS_SVH

`define LCT_CHANS     16
`define LCT_CHAN_W    4
`define LCT_CNT_W     30
`define LCT_RUN_W     16
`define LCT_DIV_W     16
`define LCT_MAX_COUNT 30'h3B9A_CA00
`define LCT_RUN_MAX   16'hFFFF
`define LCT_RUN_ONE   16'h0001
`define LCT_RUN_RAW   16'h0000
`define LCT_DRAIN_CYC 2'h3
`define LCT_QTR_SH    2

`endif

// ==== core/lct_pkg.sv ====
// Purpose: Types shared by the capture trigger modules
// Assumes: lct_defs.svh holds the widths
// Notes:   Only one trigger condition can be encoded at a time
`default_nettype none
`include "lct_defs.svh"

package lct_pkg;

  typedef enum logic [2:0] {LCT_TRIG_NONE, LCT_TRIG_HIGH, LCT_TRIG_LOW, LCT_TRIG_RISE, LCT_TRIG_FALL} lct_trig_t;

  // Quarters of the sample count kept ahead of the trigger
  typedef enum logic [2:0] {LCT_POS_0, LCT_POS_25, LCT_POS_50, LCT_POS_75, LCT_POS_100} lct_pos_t;

  typedef enum logic [1:0] {LCT_IDLE, LCT_ARMED, LCT_POST, LCT_DRAIN} lct_state_t;

  typedef struct packed {
    logic [`LCT_CHAN_W-1:0] chan;
    lct_trig_t              cond;
    lct_pos_t               pos;
    logic [`LCT_DIV_W-1:0]  rate_div;
    logic [`LCT_CNT_W-1:0]  count;
    logic                   use_pin_clock;
    logic                   run_length_capture_mode;
  } lct_cfg_t;

  typedef struct packed {
    logic                  post;
    logic [`LCT_RUN_W-1:0] run;
    logic [`LCT_CHANS-1:0] value;
  } lct_rec_t;

endpackage : lct_pkg

`default_nettype wire

// ==== core/lct_rle.sv ====
// Purpose: Turns sample strobes into raw words or run-length records
// Assumes: One sample per en pulse; clr before each capture
// Notes:   new_run tells whether the sample offered would open a record
`default_nettype none
`include "lct_defs.svh"

module lct_runlen (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Sample side
  input  wire logic                   en,
  input  wire logic [`LCT_CHANS-1:0]  data,
  input  wire logic                   tag,
  input  wire logic                   cut,
  input  wire logic                   flush,
  input  wire logic                   clr,
  input  wire logic                   raw,
  output logic                        new_run,
  // Record side
  output logic                        rec_valid,
  output lct_pkg::lct_rec_t           rec
);

  logic              have_reg;
  lct_pkg::lct_rec_t cur_reg;

  always_comb begin
    new_run = raw || !have_reg || cut || (data != cur_reg.value) || (cur_reg.run == `LCT_RUN_MAX);
  end

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      have_reg  <= 1'b0;
      cur_reg   <= '0;
      rec_valid <= 1'b0;
      rec       <= '0;
    end else begin
      rec_valid <= 1'b0;
      if (en && raw) begin
        rec_valid <= 1'b1;
        rec       <= '{post: tag, run: `LCT_RUN_RAW, value: data};
      end else if (en) begin
        if (new_run) begin
          rec_valid <= have_reg;
          rec       <= cur_reg;
          cur_reg   <= '{post: tag, run: `LCT_RUN_ONE, value: data};
          have_reg  <= 1'b1;
        end else begin
          cur_reg.run <= cur_reg.run + `LCT_RUN_ONE;
        end
      end else if (flush && have_reg) begin
        rec_valid <= 1'b1;
        rec       <= cur_reg;
        have_reg  <= 1'b0;
      end
    end
  end

endmodule : lct_runlen

`default_nettype wire

// ==== testbench/lct_probe_model.sv ====
// Purpose: Probe pins and outside sample clock of the device under test
// Assumes: Levels come from the bench and change at the falling clock edge
// Notes:   The pin clock stands still low outside a capture
`default_nettype none
`include "lct_defs.svh"

module lct_probe_model (
  // Bench side
  input  wire logic                  clk,
  input  wire logic [`LCT_CHANS-1:0] level,
  input  wire logic                  pin_run,
  input  wire logic [7:0]            pin_half,
  // Pins
  output logic      [`LCT_CHANS-1:0] probe,
  output logic                       pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] tick_reg;

  initial begin
    probe    = '0;
    pin      = 1'b0;
    tick_reg = 8'h00;
  end

  always @(negedge clk) begin
    probe <= level;
    if (!pin_run) begin
      pin      <= 1'b0;
      tick_reg <= 8'h00;
    end else if (tick_reg == pin_half - 8'h01) begin
      tick_reg <= 8'h00;
      pin      <= ~pin;
    end else begin
      tick_reg <= tick_reg + 8'h01;
    end
  end
endmodule : lct_probe_model

`default_nettype wire

// ==== testbench/lct_top_bench.sv ====
// Purpose: Self-checking bench of the capture trigger block
// Assumes: Post records are predicted; pre records only carry the idle value
// Notes:   Wildcard address 3FFF_FFFF is never a valid ring slot
`default_nettype none
`include "lct_defs.svh"
`define LCTB_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module lct_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  int                bad_count = 0;
  int                total_checks = 0;
  integer            seed = 32'hbe13;
  logic              clk, rst, start, cancel, pin_run, wr_en, busy, trig, done, aborted, pin;
  lct_pkg::lct_cfg_t cfg, c;
  lct_pkg::lct_rec_t wr_data, r;
  logic [15:0]       level, probe, pre_val, pv, qv;
  logic [7:0]        pin_half;
  logic [29:0]       wr_addr, first_addr, rec_count, a;
  lct_pkg::lct_rec_t exp_rec[$];
  logic [29:0]       exp_addr[$];
  bit                exp_any[$];
  bit                any, quiet;
  int                exp_gap, last_wr, cyc, k, q, n;

  lct_top dut (.CLK(clk), .RST(rst), .CFG(cfg), .START(start), .CANCEL(cancel), .PROBE(probe),
    .OUTSIDE_SAMPLE_CLOCK_PIN(pin), .WR_EN(wr_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .BUSY(busy),
    .TRIGGERED(trig), .DONE(done), .ABORTED(aborted), .FIRST_ADDR(first_addr), .REC_COUNT(rec_count));

  lct_probe_model src (.clk(clk), .level(level), .pin_run(pin_run), .pin_half(pin_half), .probe(probe), .pin(pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic wait_hi(ref logic s, input int lim);
    int i;
    i = 0;
    while (s !== 1'b1 && i < lim) begin
      @(negedge clk);
      i++;
    end
    if (i >= lim) begin
      bad_count++;
      conclude();
    end
  endtask : wait_hi

  task automatic note(input logic [15:0] v, input logic [15:0] run, input logic [29:0] ad, input bit dc);
    exp_rec.push_back('{post: 1'b1, run: run, value: v});
    exp_addr.push_back(ad);
    exp_any.push_back(dc);
  endtask : note

  // Start a capture, then try a second start that must be ignored
  task automatic go(input lct_pkg::lct_cfg_t s);
    last_wr = -1;
    cfg   <= s;
    start <= 1'b1;
    @(negedge clk);
    start <= 1'b0;
    wait_hi(busy, 4);
    `LCTB_CHK(trig, 1'(s.cond == lct_pkg::LCT_TRIG_NONE))
    cfg   <= lct_pkg::lct_cfg_t'(~s);
    start <= 1'b1;
    @(negedge clk);
    start <= 1'b0;
  endtask : go

  task automatic finish_chk(input int cnt, input bit untrig);
    wait_hi(done, 2000);
    `LCTB_CHK(rec_count, 30'(cnt))
    `LCTB_CHK(trig, 1'b1)
    if (untrig) `LCTB_CHK(first_addr, 30'h0000_0000)
    @(negedge clk);
    `LCTB_CHK(busy, 1'b0)
    `LCTB_CHK(exp_rec.size(), 0)
  endtask : finish_chk

  task automatic capture(input lct_pkg::lct_cfg_t s, input logic [15:0] pre, input logic [15:0] post, input int qq);
    int cnt, npre, i;
    cnt  = (s.count == 30'h0000_0000) ? 1 : int'(s.count);
    npre = (s.cond == lct_pkg::LCT_TRIG_NONE) ? 0 : cnt * qq / 4;
    for (i = 0; i < cnt - npre; i++) begin
      note(post, 16'h0000, (s.cond == lct_pkg::LCT_TRIG_NONE) ? 30'(i) : 30'h3FFF_FFFF, 1'b0);
    end
    pre_val = pre;
    level <= pre;
    // Let the new level clear the probe and sync stages before arming
    repeat (3) @(negedge clk);
    go(s);
    // An untriggered run may end inside this wait, so only triggered runs hold the pre level
    if (s.cond != lct_pkg::LCT_TRIG_NONE) begin
      repeat (cnt + 6) @(negedge clk);
    end
    level <= post;
    finish_chk(cnt, s.cond == lct_pkg::LCT_TRIG_NONE);
  endtask : capture

  // Record monitor: pops the oldest note for each post record
  always @(negedge clk) begin
    if (wr_en === 1'b1) begin
      `LCTB_CHK(quiet, 1'b0)
      if (exp_gap != 0 && last_wr >= 0) `LCTB_CHK(cyc - last_wr, exp_gap)
      last_wr = cyc;
      if (wr_data.post !== 1'b1) `LCTB_CHK(wr_data.value, pre_val)
      else if (exp_rec.size() == 0) `LCTB_CHK(wr_data.post, 1'b0)
      else begin
        r   = exp_rec.pop_front();
        a   = exp_addr.pop_front();
        any = exp_any.pop_front();
        if (any) r.run = wr_data.run;
        `LCTB_CHK(wr_data, r)
        if (a != 30'h3FFF_FFFF) `LCTB_CHK(wr_addr, a)
      end
    end
  end

  initial begin
    rst = 1'b1; start = 1'b0; cancel = 1'b0; cfg = '0; level = '0; pin_run = 1'b0; pin_half = 8'h03;
    quiet = 1'b0; exp_gap = 0; last_wr = -1; cyc = 0; pre_val = '0;
    repeat (10) @(negedge clk);
    rst <= 1'b0;
    cancel <= 1'b1;
    @(negedge clk);
    cancel <= 1'b0;
    `LCTB_CHK(aborted, 1'b0)
    @(negedge clk);
    `LCTB_CHK(aborted, 1'b0)
    // Untriggered, count zero taken as one
    for (n = 0; n < 6; n += 5) begin
      c = '0;
      c.count = 30'(n);
      pv = 16'($random(seed));
      capture(c, pv, pv, 0);
    end
    exp_gap = 4;
    c = '0;
    c.count = 30'h0000_0004;
    c.rate_div = 16'h0003;
    capture(c, 16'hA5C3, 16'hA5C3, 0);
    exp_gap = 6;
    c.rate_div = 16'hFFFF;
    c.use_pin_clock = 1'b1;
    pin_run <= 1'b1;
    capture(c, 16'h5A3C, 16'h5A3C, 0);
    pin_run <= 1'b0;
    exp_gap = 0;
    // Every condition at every pre-trigger share
    for (k = 1; k < 5; k++) begin
      for (q = 0; q < 5; q++) begin
        c = '0;
        c.cond = lct_pkg::lct_trig_t'(k);
        c.pos = lct_pkg::lct_pos_t'(q);
        c.chan = 4'($random(seed));
        c.count = 30'(1 + {$random(seed)} % 12);
        pv = 16'($random(seed));
        qv = 16'($random(seed));
        pv[c.chan] = !(k == 1 || k == 3);
        qv[c.chan] = (k == 1 || k == 3);
        capture(c, pv, qv, q);
      end
    end
    // Cancel while waiting for a trigger that never comes
    c = '0;
    c.cond = lct_pkg::LCT_TRIG_HIGH;
    c.count = 30'h0000_0008;
    pre_val = 16'h0000;
    level <= 16'h0000;
    // A stale level from the last run would trigger at once
    repeat (3) @(negedge clk);
    go(c);
    repeat (10) @(negedge clk);
    cancel <= 1'b1;
    @(negedge clk);
    cancel <= 1'b0;
    wait_hi(aborted, 3);
    `LCTB_CHK(busy, 1'b0)
    quiet = 1'b1;
    repeat (20) begin
      @(negedge clk);
      `LCTB_CHK(done, 1'b0)
    end
    quiet = 1'b0;
    // Run-length records: first run length unknown, then 3 and 4
    c = '0;
    c.run_length_capture_mode = 1'b1;
    c.count = 30'h0000_0003;
    note(16'h1111, 16'h0000, 30'h0000_0000, 1'b1);
    note(16'h2222, 16'h0003, 30'h0000_0001, 1'b0);
    note(16'h3333, 16'h0004, 30'h0000_0002, 1'b0);
    level <= 16'h1111;
    repeat (3) @(negedge clk);
    go(c);
    repeat (3) @(negedge clk);
    level <= 16'h2222;
    repeat (3) @(negedge clk);
    level <= 16'h3333;
    repeat (4) @(negedge clk);
    level <= 16'h4444;
    finish_chk(3, 1'b1);
    conclude();
  end
endmodule : lct_top_bench

`default_nettype wire
